// ---- shared/ufc_map.svh ----
`ifndef UFC_MAP_SVH
`define UFC_MAP_SVH

// ********************************************************************
// Sizes
// ********************************************************************
`define UFC_WORD_W        32
`define UFC_TX_DEPTH      3072
`define UFC_RX_DEPTH      16
`define UFC_RX_LVL_W      5
`define UFC_LEN_W         20
`define UFC_WORDS_W       19

// ********************************************************************
// Command A field positions
// ********************************************************************
`define UFC_CMDA_IGMP_BIT 29
`define UFC_CMDA_ICMP_BIT 28
`define UFC_CMDA_SEG_BIT  27
`define UFC_CMDA_IP_BIT   26
`define UFC_CMDA_TU_BIT   25
`define UFC_CMDA_VINS_BIT 24
`define UFC_CMDA_VOVR_BIT 23
`define UFC_CMDA_FCS_BIT  22
`define UFC_CMDA_LEN_MSB  19

// ********************************************************************
// Timing and padding values
// ********************************************************************
`define UFC_FLUSH_CYCLES  3'h4
`define UFC_FLUSH_LAST    3'h3
`define UFC_LEN_PAD       12'h000

`endif

// ---- shared/ufc_pkg.sv ----
package ufc_pkg;
  `include "ufc_map.svh"

  typedef enum logic [2:0] {
    UFC_TX_CMDA,
    UFC_TX_LEN,
    UFC_TX_CMDA_WR,
    UFC_TX_CMDB,
    UFC_TX_DATA
  } ufc_tx_state_t;

  typedef struct packed {
    logic igmp;
    logic icmp;
    logic seg;
    logic ip;
    logic tu;
    logic vins;
    logic vovr;
    logic fcs;
  } ufc_cmd_flags_t;

  // Offload checksum bits lose their meaning under segmentation offload
  function automatic ufc_cmd_flags_t ufc_decode_cmda(
    input logic [`UFC_WORD_W-1:0] cmd
  );
    ufc_cmd_flags_t f;
    logic           seg;
    seg    = cmd[`UFC_CMDA_SEG_BIT];
    f.igmp = cmd[`UFC_CMDA_IGMP_BIT] & ~seg;
    f.icmp = cmd[`UFC_CMDA_ICMP_BIT] & ~seg;
    f.seg  = seg;
    f.ip   = cmd[`UFC_CMDA_IP_BIT] & ~seg;
    f.tu   = cmd[`UFC_CMDA_TU_BIT] & ~seg;
    f.vins = cmd[`UFC_CMDA_VINS_BIT];
    f.vovr = cmd[`UFC_CMDA_VINS_BIT] & cmd[`UFC_CMDA_VOVR_BIT];
    f.fcs  = cmd[`UFC_CMDA_FCS_BIT];
    return f;
  endfunction : ufc_decode_cmda
endpackage : ufc_pkg

// ---- shared/ufc_stream_if.sv ----
`timescale 1ns/100ps
interface ufc_stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport snk (input valid, input data, output ready);
  modport src (output valid, output data, input ready);
endinterface : ufc_stream_if

// ---- design/ufc_fifo.sv ----
`timescale 1ns/100ps
module ufc_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  input  wire logic                        flush_in,
  ufc_stream_if.snk                        in_s,
  ufc_stream_if.src                        out_s,
  output logic [$clog2(DEPTH+2)-1:0]       level_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+2);
  localparam logic [AW-1:0] LAST = AW'(DEPTH-1);
  localparam logic [LW-1:0] FULL = LW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [LW-1:0] cnt_q, cnt_d;
  logic          ov_q, ov_d;
  logic [W-1:0]  dout_q, dout_d;
  logic          wr, load;

  // ******************************************************************
  // Storage plus one output register, so read data leave a flip-flop
  // ******************************************************************
  assign in_s.ready  = (cnt_q != FULL) & ~flush_in;
  assign out_s.valid = ov_q;
  assign out_s.data  = dout_q;
  assign level_out   = cnt_q + LW'(ov_q);

  always_comb begin
    wr       = in_s.valid & in_s.ready;
    load     = (cnt_q != '0) & (~ov_q | out_s.ready);
    wr_ptr_d = wr ? ((wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1) : wr_ptr_q;
    rd_ptr_d = load ? ((rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1)
                    : rd_ptr_q;
    cnt_d    = cnt_q + LW'(wr) - LW'(load);
    ov_d     = load | (ov_q & ~out_s.ready);
    dout_d   = load ? mem[rd_ptr_q] : dout_q;
    if (flush_in) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      cnt_d    = '0;
      ov_d     = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr) begin
      mem[wr_ptr_q] <= in_s.data;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
      ov_q     <= 1'b0;
      dout_q   <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q    <= cnt_d;
      ov_q     <= ov_d;
      dout_q   <= dout_d;
    end
  end

  a_fifo_bound : assert property (@(posedge clk_in) disable iff (rst_in)
    cnt_q <= FULL) else $error("fifo count above depth");
  a_fifo_flush : assert property (@(posedge clk_in) disable iff (rst_in)
    flush_in |=> (level_out == '0)) else $error("flush left data");
endmodule : ufc_fifo

// ---- design/ufc_top.sv ----
`timescale 1ns/100ps
`include "ufc_map.svh"
module ufc_top
  import ufc_pkg::*;
(
  input  wire logic                     core_clk_in,
  input  wire logic                     reset_in,
  input  wire logic                     rx_fifo_enable_in,
  input  wire logic                     rx_fifo_flush_set_in,
  output logic                          rx_fifo_disabled_out,
  output logic                          rx_fifo_flush_bit_out,
  input  wire logic                     receiver_enable_bit_in,
  input  wire logic                     mac_rx_halted_in,
  input  wire logic                     receiver_disabled_clr_in,
  output logic                          receiver_disabled_status_out,
  input  wire logic                     rx_disabled_irq_en_in,
  output logic                          rx_disabled_irq_out,
  input  wire logic [`UFC_RX_LVL_W-1:0] fc_on_thresh_in,
  input  wire logic [`UFC_RX_LVL_W-1:0] fc_off_thresh_in,
  input  wire logic                     tx_pause_enable_in,
  output logic                          mac_fc_on_out,
  output logic                          mac_fc_off_out,
  output logic                          mac_pause_send_out,
  output logic                          mac_pause_zero_out,
  input  wire logic [`UFC_WORD_W-1:0]   mac_rx_data_in,
  input  wire logic                     mac_rx_valid_in,
  output logic                          mac_rx_ready_out,
  output logic [`UFC_WORD_W-1:0]        rx_fifo_data_out,
  output logic                          rx_fifo_valid_out,
  input  wire logic                     rx_fifo_ready_in,
  output logic [`UFC_RX_LVL_W-1:0]      rx_fifo_level_out,
  input  wire logic [`UFC_WORD_W-1:0]   usb_rx_data_in,
  input  wire logic                     usb_rx_valid_in,
  output logic                          usb_rx_ready_out,
  output logic [`UFC_WORD_W-1:0]        tx_fifo_data_out,
  output logic                          tx_fifo_valid_out,
  input  wire logic                     tx_fifo_ready_in,
  output logic                          tx_cmd_valid_out,
  output logic [`UFC_LEN_W-1:0]         tx_frame_len_out,
  output logic                          igmp_sum_offload_en_out,
  output logic                          icmp_sum_offload_en_out,
  output logic                          tcp_segmentation_enable_out,
  output logic                          ip_header_sum_en_out,
  output logic                          tcp_udp_sum_en_out,
  output logic                          vlan_insert_en_out,
  output logic                          vlan_overwrite_en_out,
  output logic                          fcs_pad_en_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  ufc_stream_if #(.W(`UFC_WORD_W)) rx_in ();
  ufc_stream_if #(.W(`UFC_WORD_W)) rx_out ();
  ufc_stream_if #(.W(`UFC_WORD_W)) tx_in ();
  ufc_stream_if #(.W(`UFC_WORD_W)) tx_out ();

  // ******************************************************************
  // RX FIFO disable, flush and receiver status
  // ******************************************************************
  logic       dis_q, dis_d, flush_q, flush_d, rxd_q, rxd_d, irq_q, irq_d;
  logic [2:0] fcnt_q, fcnt_d;
  logic       rx_run;
  logic [`UFC_RX_LVL_W-1:0] rx_lvl;

  // Traffic is gated while disabled, so no word is ever half moved
  assign rx_run = rx_fifo_enable_in & ~flush_q;

  always_comb begin
    dis_d   = ~rx_fifo_enable_in;
    flush_d = flush_q;
    fcnt_d  = fcnt_q;
    if (flush_q) begin
      fcnt_d = fcnt_q + 3'h1;
      if (fcnt_q == `UFC_FLUSH_LAST) begin
        flush_d = 1'b0;
      end
    end else if (rx_fifo_flush_set_in & dis_q) begin
      flush_d = 1'b1;
      fcnt_d  = 3'h0;
    end
    // Halt event wins over a clear in the same cycle
    rxd_d = (rxd_q & ~receiver_disabled_clr_in)
          | (~receiver_enable_bit_in & mac_rx_halted_in);
    irq_d = (irq_q | (rx_disabled_irq_en_in & (dis_d | rxd_d)))
          & (dis_q | rxd_q | dis_d | rxd_d);
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      dis_q   <= 1'b1;
      flush_q <= 1'b0;
      fcnt_q  <= 3'h0;
      rxd_q   <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      dis_q   <= dis_d;
      flush_q <= flush_d;
      fcnt_q  <= fcnt_d;
      rxd_q   <= rxd_d;
      irq_q   <= irq_d;
    end
  end

  assign rx_fifo_disabled_out         = dis_q;
  assign rx_fifo_flush_bit_out        = flush_q;
  assign receiver_disabled_status_out = rxd_q;
  assign rx_disabled_irq_out          = irq_q;

  assign rx_in.valid       = mac_rx_valid_in & rx_run;
  assign rx_in.data        = mac_rx_data_in;
  assign mac_rx_ready_out  = rx_in.ready & rx_run;
  assign rx_fifo_valid_out = rx_out.valid & rx_run;
  assign rx_fifo_data_out  = rx_out.data;
  assign rx_out.ready      = rx_fifo_ready_in & rx_run;
  assign rx_fifo_level_out = rx_lvl;

  ufc_fifo #(.W(`UFC_WORD_W), .DEPTH(`UFC_RX_DEPTH)) u_rx_fifo (
    .clk_in    (core_clk_in),
    .rst_in    (reset_in),
    .flush_in  (flush_q),
    .in_s      (rx_in),
    .out_s     (rx_out),
    .level_out (rx_lvl)
  );

  // ******************************************************************
  // Flow control with hysteresis
  // ******************************************************************
  logic fc_q, fc_d, on_q, on_d, off_q, off_d, ps_q, ps_d, pz_q, pz_d;

  always_comb begin
    fc_d  = fc_q;
    on_d  = 1'b0;
    off_d = 1'b0;
    if (~fc_q & (rx_lvl > fc_on_thresh_in)) begin
      fc_d = 1'b1;
      on_d = 1'b1;
    end else if (fc_q & (rx_lvl < fc_off_thresh_in)) begin
      fc_d  = 1'b0;
      off_d = 1'b1;
    end
    ps_d = (on_d | off_d) & tx_pause_enable_in;
    pz_d = off_d & tx_pause_enable_in;
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      fc_q  <= 1'b0;
      on_q  <= 1'b0;
      off_q <= 1'b0;
      ps_q  <= 1'b0;
      pz_q  <= 1'b0;
    end else begin
      fc_q  <= fc_d;
      on_q  <= on_d;
      off_q <= off_d;
      ps_q  <= ps_d;
      pz_q  <= pz_d;
    end
  end

  assign mac_fc_on_out      = on_q;
  assign mac_fc_off_out     = off_q;
  assign mac_pause_send_out = ps_q;
  assign mac_pause_zero_out = pz_q;

  // ******************************************************************
  // TX write side: length word, command A, then pass-through
  // ******************************************************************
  ufc_tx_state_t            st_q, st_d;
  logic [`UFC_WORD_W-1:0]   cmda_q, cmda_d;
  logic [`UFC_WORDS_W-1:0]  words_q, words_d;
  ufc_cmd_flags_t           flg_q, flg_d;
  logic                     cv_q, cv_d;
  logic [`UFC_LEN_W:0]      len_rnd;

  // Data words are taken as is; errored packets never reach here
  assign len_rnd = {1'b0, usb_rx_data_in[`UFC_CMDA_LEN_MSB:0]}
                 + 21'h000003;

  always_comb begin
    st_d             = st_q;
    cmda_d           = cmda_q;
    words_d          = words_q;
    flg_d            = flg_q;
    cv_d             = 1'b0;
    usb_rx_ready_out = 1'b0;
    tx_in.valid      = 1'b0;
    tx_in.data       = usb_rx_data_in;
    case (st_q)
      UFC_TX_CMDA: begin
        usb_rx_ready_out = 1'b1;
        if (usb_rx_valid_in) begin
          cmda_d  = usb_rx_data_in;
          words_d = len_rnd[`UFC_LEN_W:2];
          flg_d   = ufc_decode_cmda(usb_rx_data_in);
          cv_d    = 1'b1;
          st_d    = UFC_TX_LEN;
        end
      end
      UFC_TX_LEN: begin
        tx_in.valid = 1'b1;
        tx_in.data  = {`UFC_LEN_PAD,
                       cmda_q[`UFC_CMDA_LEN_MSB:0]};
        if (tx_in.ready) begin
          st_d = UFC_TX_CMDA_WR;
        end
      end
      UFC_TX_CMDA_WR: begin
        tx_in.valid = 1'b1;
        tx_in.data  = cmda_q;
        if (tx_in.ready) begin
          st_d = UFC_TX_CMDB;
        end
      end
      UFC_TX_CMDB, UFC_TX_DATA: begin
        tx_in.valid      = usb_rx_valid_in;
        usb_rx_ready_out = tx_in.ready;
        if (usb_rx_valid_in & tx_in.ready) begin
          if (st_q == UFC_TX_DATA) begin
            words_d = words_q - 19'h00001;
          end
          if ((st_q == UFC_TX_DATA) ? (words_q == 19'h00001)
                                    : (words_q == '0)) begin
            st_d = UFC_TX_CMDA;
          end else begin
            st_d = UFC_TX_DATA;
          end
        end
      end
      default: begin
        st_d = UFC_TX_CMDA;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_q    <= UFC_TX_CMDA;
      cmda_q  <= '0;
      words_q <= '0;
      flg_q   <= '0;
      cv_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      cmda_q  <= cmda_d;
      words_q <= words_d;
      flg_q   <= flg_d;
      cv_q    <= cv_d;
    end
  end

  ufc_fifo #(.W(`UFC_WORD_W), .DEPTH(`UFC_TX_DEPTH)) u_tx_fifo (
    .clk_in    (core_clk_in),
    .rst_in    (reset_in),
    .flush_in  (1'b0),
    .in_s      (tx_in),
    .out_s     (tx_out),
    .level_out ()
  );

  assign tx_fifo_valid_out = tx_out.valid;
  assign tx_fifo_data_out  = tx_out.data;
  assign tx_out.ready      = tx_fifo_ready_in;

  // Sideband for the read side and the MAC
  assign tx_cmd_valid_out            = cv_q;
  assign tx_frame_len_out            = cmda_q[`UFC_CMDA_LEN_MSB:0];
  assign igmp_sum_offload_en_out     = flg_q.igmp;
  assign icmp_sum_offload_en_out     = flg_q.icmp;
  assign tcp_segmentation_enable_out = flg_q.seg;
  assign ip_header_sum_en_out        = flg_q.ip;
  assign tcp_udp_sum_en_out          = flg_q.tu;
  assign vlan_insert_en_out          = flg_q.vins;
  assign vlan_overwrite_en_out       = flg_q.vovr;
  assign fcs_pad_en_out              = flg_q.fcs;

  // ******************************************************************
  // Checks
  // ******************************************************************
  a_dis_after_en : assert property (
    !rx_fifo_enable_in |=> rx_fifo_disabled_out)
    else $error("disabled status missing");
  a_flush_self_clr : assert property (
    $rose(flush_q) |-> flush_q [*4] ##1 !flush_q)
    else $error("flush bit did not self clear in time");
  a_flush_refused : assert property (
    rx_fifo_flush_set_in && !dis_q && !flush_q |=> !flush_q)
    else $error("flush accepted while enabled");
  a_irq_hold_clear : assert property (
    irq_q && !(dis_q || rxd_q) && !dis_d && !rxd_d |=> !irq_q)
    else $error("irq stayed after both status bits cleared");
  a_rxd_on_halt : assert property (
    !receiver_enable_bit_in && mac_rx_halted_in |=> rxd_q)
    else $error("receiver disabled status missing");
  a_fc_on_pulse : assert property (
    !fc_q && rx_lvl > fc_on_thresh_in |=> mac_fc_on_out ##1 !mac_fc_on_out)
    else $error("flow on pulse wrong");
  a_fc_off_pulse : assert property (
    fc_q && rx_lvl < fc_off_thresh_in |=> mac_fc_off_out && !fc_q)
    else $error("flow off pulse wrong");
  a_pause_gate : assert property (
    mac_pause_send_out |-> $past(tx_pause_enable_in)
      && (mac_fc_on_out || mac_fc_off_out))
    else $error("pause request without enable");
  a_fc_hysteresis : assert property (
    rx_lvl <= fc_on_thresh_in && rx_lvl >= fc_off_thresh_in |=> $stable(fc_q))
    else $error("flow state moved between thresholds");
  a_len_word_first : assert property (
    st_q == UFC_TX_LEN && tx_in.ready |=> tx_in.valid
      && tx_in.data == cmda_q && st_q == UFC_TX_CMDA_WR)
    else $error("command A not after length word");
  a_seg_masks_sums : assert property (
    tcp_segmentation_enable_out |-> !igmp_sum_offload_en_out
      && !icmp_sum_offload_en_out && !ip_header_sum_en_out
      && !tcp_udp_sum_en_out)
    else $error("checksum flag under segmentation");

  c_flush_done : cover property ($fell(flush_q));
  c_fc_cycle   : cover property (mac_fc_on_out ##[1:200] mac_fc_off_out);
  c_tx_frame   : cover property (st_q == UFC_TX_DATA ##1 st_q == UFC_TX_CMDA);
endmodule : ufc_top

// ---- testbench/ufc_far_model.sv ----
`timescale 1ns/100ps
// ****************************************
// MAC receive source and MAC transmit sink
// ****************************************
module ufc_far_model (
  input  wire logic        clk_in,
  input  wire logic        send_in,
  input  wire logic        rx_ready_in,
  output logic             rx_valid_out,
  output logic [31:0]      rx_data_out,
  input  wire logic [31:0] tx_data_in,
  input  wire logic        tx_valid_in,
  output logic             tx_ready_out
);
  logic [31:0] cnt_q = 32'h0;
  logic [1:0]  ph_q  = 2'h0;
  logic        vld_q = 1'b0;
  logic [31:0] got[$];
  // Idle data is inverted so a stale word never passes as a good one
  assign rx_valid_out = vld_q;
  assign rx_data_out  = vld_q ? cnt_q : ~cnt_q;
  // Sink stalls one cycle in four to exercise TX backpressure
  assign tx_ready_out = (ph_q != 2'h3);
  always @(posedge clk_in) begin
    ph_q <= ph_q + 2'h1;
    if (vld_q && rx_ready_in) cnt_q <= cnt_q + 32'h1;
    if (!vld_q || rx_ready_in) vld_q <= send_in;
    if (tx_valid_in && tx_ready_out) got.push_back(tx_data_in);
  end
endmodule : ufc_far_model

// ---- testbench/usb_eth_fifo_frame_control_tb.sv ----
`timescale 1ns/100ps
module usb_eth_fifo_frame_control_tb;
  logic core_clk_in, reset_in, rx_fifo_enable_in, rx_fifo_flush_set_in;
  logic receiver_enable_bit_in, mac_rx_halted_in, receiver_disabled_clr_in;
  logic rx_disabled_irq_en_in, tx_pause_enable_in, mac_rx_valid_in;
  logic rx_fifo_ready_in, usb_rx_valid_in, tx_fifo_ready_in, send;
  logic [4:0]  fc_on_thresh_in, fc_off_thresh_in, rx_fifo_level_out;
  logic [31:0] mac_rx_data_in, usb_rx_data_in, rx_fifo_data_out;
  logic [31:0] tx_fifo_data_out, exp_q[$];
  logic [19:0] tx_frame_len_out;
  logic rx_fifo_disabled_out, rx_fifo_flush_bit_out, rx_disabled_irq_out;
  logic receiver_disabled_status_out, mac_fc_on_out, mac_fc_off_out;
  logic mac_pause_send_out, mac_pause_zero_out, mac_rx_ready_out;
  logic rx_fifo_valid_out, usb_rx_ready_out, tx_fifo_valid_out;
  logic tx_cmd_valid_out, igmp_sum_offload_en_out, icmp_sum_offload_en_out;
  logic tcp_segmentation_enable_out, ip_header_sum_en_out;
  logic tcp_udp_sum_en_out, vlan_insert_en_out, vlan_overwrite_en_out;
  logic fcs_pad_en_out, chk_rx;
  logic [7:0] flags;
  int num_errors, checks_done, n_on, n_off, n_send, n_zero, n_cmd, rx_exp;
  int i, lvl;
  assign flags = {igmp_sum_offload_en_out, icmp_sum_offload_en_out,
    tcp_segmentation_enable_out, ip_header_sum_en_out, tcp_udp_sum_en_out,
    vlan_insert_en_out, vlan_overwrite_en_out, fcs_pad_en_out};

  ufc_top u_dut (.core_clk_in, .reset_in, .rx_fifo_enable_in,
    .rx_fifo_flush_set_in, .rx_fifo_disabled_out, .rx_fifo_flush_bit_out,
    .receiver_enable_bit_in, .mac_rx_halted_in, .receiver_disabled_clr_in,
    .receiver_disabled_status_out, .rx_disabled_irq_en_in,
    .rx_disabled_irq_out, .fc_on_thresh_in, .fc_off_thresh_in,
    .tx_pause_enable_in, .mac_fc_on_out, .mac_fc_off_out,
    .mac_pause_send_out, .mac_pause_zero_out, .mac_rx_data_in,
    .mac_rx_valid_in, .mac_rx_ready_out, .rx_fifo_data_out,
    .rx_fifo_valid_out, .rx_fifo_ready_in, .rx_fifo_level_out,
    .usb_rx_data_in, .usb_rx_valid_in, .usb_rx_ready_out, .tx_fifo_data_out,
    .tx_fifo_valid_out, .tx_fifo_ready_in, .tx_cmd_valid_out,
    .tx_frame_len_out, .igmp_sum_offload_en_out, .icmp_sum_offload_en_out,
    .tcp_segmentation_enable_out, .ip_header_sum_en_out, .tcp_udp_sum_en_out,
    .vlan_insert_en_out, .vlan_overwrite_en_out, .fcs_pad_en_out);

  ufc_far_model u_far (.clk_in(core_clk_in), .send_in(send),
    .rx_ready_in(mac_rx_ready_out), .rx_valid_out(mac_rx_valid_in),
    .rx_data_out(mac_rx_data_in), .tx_data_in(tx_fifo_data_out),
    .tx_valid_in(tx_fifo_valid_out), .tx_ready_out(tx_fifo_ready_in));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic lim(input int n);
    if (n >= 200) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : lim

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : tick

  // Word is held until the edge at which ready is seen high
  task automatic usb_put(input logic [31:0] w);
    int k;
    k = 0;
    usb_rx_data_in  <= w;
    usb_rx_valid_in <= 1'b1;
    do begin
      @(posedge core_clk_in);
      k++;
    end while (usb_rx_ready_out !== 1'b1 && k < 200);
    lim(k);
  endtask : usb_put

  task automatic frame(input logic [31:0] a, input logic [31:0] b,
                       input int n);
    exp_q.push_back({12'h000, a[19:0]});
    exp_q.push_back(a);
    exp_q.push_back(b);
    usb_put(a);
    usb_put(b);
    for (int k = 0; k < n; k++) begin
      exp_q.push_back(32'hA500_0000 + k);
      usb_put(32'hA500_0000 + k);
    end
  endtask : frame

  always #2.5 core_clk_in = ~core_clk_in;

  always @(posedge core_clk_in) begin
    n_on   += mac_fc_on_out;
    n_off  += mac_fc_off_out;
    n_send += mac_pause_send_out;
    n_zero += mac_pause_zero_out;
    n_cmd  += tx_cmd_valid_out;
    if (chk_rx && rx_fifo_valid_out && rx_fifo_ready_in) begin
      chk(rx_fifo_data_out, rx_exp);
      rx_exp++;
    end
  end

  initial begin
    {core_clk_in, rx_fifo_flush_set_in, receiver_disabled_clr_in} = '0;
    {rx_disabled_irq_en_in, tx_pause_enable_in, rx_fifo_ready_in} = '0;
    {usb_rx_valid_in, send, chk_rx, mac_rx_halted_in} = '0;
    {reset_in, rx_fifo_enable_in, receiver_enable_bit_in} = 3'h7;
    {fc_on_thresh_in, fc_off_thresh_in, usb_rx_data_in} = '0;
    tick(6);
    chk(rx_fifo_disabled_out, 1'b1);
    chk(rx_fifo_flush_bit_out, 1'b0);
    chk(rx_disabled_irq_out, 1'b0);
    chk(usb_rx_ready_out, 1'b1);
    reset_in <= 1'b0;
    fc_on_thresh_in  <= 5'h08;
    fc_off_thresh_in <= 5'h03;
    tx_pause_enable_in <= 1'b1;
    send <= 1'b1;
    for (i = 0; mac_rx_ready_out !== 1'b0 && i < 200; i++) tick(1);
    lim(i);
    chk(rx_fifo_level_out, 5'h11);
    chk(n_on, 1);
    chk(n_send, 1);
    chk(n_off, 0);
    send <= 1'b0;
    rx_fifo_ready_in <= 1'b1;
    chk_rx <= 1'b1;
    for (i = 0; rx_fifo_level_out !== 5'h00 && i < 200; i++) tick(1);
    lim(i);
    tick(3);
    chk(n_off, 1);
    chk(n_zero, 1);
    chk(n_send, 2);
    chk(rx_exp, 18);
    rx_fifo_ready_in <= 1'b0;
    chk_rx <= 1'b0;
    tx_pause_enable_in <= 1'b0;
    send <= 1'b1;
    for (i = 0; rx_fifo_level_out < 5'h0A && i < 200; i++) tick(1);
    lim(i);
    send <= 1'b0;
    rx_disabled_irq_en_in <= 1'b1;
    receiver_enable_bit_in <= 1'b0;
    mac_rx_halted_in <= 1'b1;
    tick(3);
    chk(n_on, 2);
    chk(n_send, 2);
    chk(receiver_disabled_status_out, 1'b1);
    chk(rx_disabled_irq_out, 1'b1);
    lvl = rx_fifo_level_out;
    rx_fifo_flush_set_in <= 1'b1;
    tick(1);
    rx_fifo_flush_set_in <= 1'b0;
    tick(3);
    chk(rx_fifo_flush_bit_out, 1'b0);
    chk(rx_fifo_level_out, lvl);
    rx_fifo_enable_in <= 1'b0;
    for (i = 0; rx_fifo_disabled_out !== 1'b1 && i < 200; i++) tick(1);
    lim(i);
    rx_fifo_flush_set_in <= 1'b1;
    tick(1);
    rx_fifo_flush_set_in <= 1'b0;
    for (i = 0; rx_fifo_flush_bit_out !== 1'b1 && i < 200; i++) tick(1);
    lim(i);
    for (i = 0; rx_fifo_flush_bit_out === 1'b1 && i < 200; i++) tick(1);
    chk(i, 4);
    chk(rx_fifo_level_out, 5'h00);
    receiver_enable_bit_in <= 1'b1;
    mac_rx_halted_in <= 1'b0;
    receiver_disabled_clr_in <= 1'b1;
    tick(1);
    receiver_disabled_clr_in <= 1'b0;
    tick(2);
    chk(receiver_disabled_status_out, 1'b0);
    chk(rx_disabled_irq_out, 1'b1);
    rx_fifo_enable_in <= 1'b1;
    tick(3);
    chk(rx_fifo_disabled_out, 1'b0);
    chk(rx_disabled_irq_out, 1'b0);
    frame(32'h3FC0_0009, 32'h0008_0ABC, 3);
    chk(flags, 8'h27);
    chk(tx_frame_len_out, 20'h00009);
    frame(32'h3740_0005, 32'h0000_0123, 2);
    usb_rx_valid_in <= 1'b0;
    for (i = 0; u_far.got.size() < 11 && i < 200; i++) tick(1);
    lim(i);
    chk(flags, 8'hDD);
    chk(n_cmd, 2);
    for (i = 0; i < 11; i++) chk(u_far.got[i], exp_q[i]);
    tally_and_finish();
  end
endmodule : usb_eth_fifo_frame_control_tb
